// ### hw/ncrh_pkg.sv
// Package of constants and types for the configuration request handler
//==============================================================================
// Contract
// - Update executes only after five actuations in each harvester direction.
// - Primary request: identifier 0x11 then three zero bytes at block 0x0050.
// - Secondary request: identifier 0x19 then three zero bytes.
// - PIN word at block 0x0052 is checked against the requesting user's PIN.
// - Mask bits at block 0x0051 select which registers are updated.
// - Primary results: 0x31 success, 0x51 in progress, 0x71 PIN error.
// - Primary results: 0x91 not modifiable, 0xb1 invalid value.
// - Secondary results: 0x39 success, 0x59 in progress, 0x79 PIN error.
// - Secondary results: 0x99 not modifiable or disabled, 0xb9 invalid value.
// - Secondary requests use the same sequence; codes, PIN and results differ.
// - Primary PIN change accepted only from authenticated primary user.
// - Mask bit 0x40 of byte 0 selects primary PIN, staged at block 0x0079.
// - Primary PIN never changes without the current primary PIN.
// - Primary and secondary PINs are both changeable by configuration requests.
`default_nettype none
package ncrh_pkg;
   // Block addresses
   localparam logic [7:0] ADDR_REQ_ID    = 8'h50;
   localparam logic [7:0] ADDR_SEL_MASK  = 8'h51;
   localparam logic [7:0] ADDR_PIN_WORD  = 8'h52;
   localparam logic [7:0] ADDR_STATUS    = 8'h53;
   localparam logic [7:0] ADDR_STAGE_LO  = 8'h70;
   localparam logic [7:0] ADDR_P_PIN_NEW = 8'h79;
   localparam logic [7:0] ADDR_STAGE_HI  = 8'h7f;
   // Request identifiers
   localparam logic [31:0] REQ_PRIMARY   = 32'h0000_0011;
   localparam logic [31:0] REQ_SECONDARY = 32'h0000_0019;
   // Result codes, primary / secondary
   localparam logic [7:0] RES_P_OK   = 8'h31;
   localparam logic [7:0] RES_P_BUSY = 8'h51;
   localparam logic [7:0] RES_P_PIN  = 8'h71;
   localparam logic [7:0] RES_P_PERM = 8'h91;
   localparam logic [7:0] RES_P_PARM = 8'hb1;
   localparam logic [7:0] RES_S_OK   = 8'h39;
   localparam logic [7:0] RES_S_BUSY = 8'h59;
   localparam logic [7:0] RES_S_PIN  = 8'h79;
   localparam logic [7:0] RES_S_PERM = 8'h99;
   localparam logic [7:0] RES_S_PARM = 8'hb9;
   localparam logic [7:0] RES_IDLE   = 8'h00;
   // Selection mask fields
   localparam int         SEL_P_PIN_BIT = 6;
   localparam int         SEL_S_PIN_BIT = 7;
   localparam logic [3:0] STAGE_IDX_LO  = 4'h0;
   // Reset values
   localparam logic [31:0] P_PIN_RESET   = 32'he535_0002;
   localparam logic [31:0] S_PIN_RESET   = 32'he535_0003;
   localparam logic [31:0] ALLOWED_RESET = 32'h3337_37d7;
   localparam logic [31:0] S_ALLOWED_RESET = 32'h3337_3787;
   // Actuations needed per direction
   localparam logic [2:0] ACT_NEEDED = 3'h5;

   // Tag block access (write or read) from the reader
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] data;
   } ncrh_tag_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_EXEC = 2'b10
   } ncrh_state_e;

   typedef enum logic [1:0] {
      USR_NONE      = 2'b00,
      USR_PRIMARY   = 2'b01,
      USR_SECONDARY = 2'b10
   } ncrh_user_e;
endpackage
`default_nettype wire

// ### hw/ncrh_energy.sv
// Harvester actuation counter that gates execution
`default_nettype none
module ncrh_energy #(
   parameter logic [2:0] NEEDED = ncrh_pkg::ACT_NEEDED
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Actuation pulses
   input  wire logic clear_i,
   input  wire logic press_i,
   input  wire logic release_i,
   // Energy reached
   output logic      ready_o
);
   typedef struct packed {
      logic [2:0] press_cnt;
      logic [2:0] rel_cnt;
   } ncrh_en_s;

   ncrh_en_s st;
   ncrh_en_s next_st;

   // Saturating counts per direction
   always_comb
   begin
      next_st = st;
      if (clear_i)
      begin
         next_st = '0;
      end
      else
      begin
         if (press_i && st.press_cnt != NEEDED)
            next_st.press_cnt = st.press_cnt + 3'h1;
         if (release_i && st.rel_cnt != NEEDED)
            next_st.rel_cnt = st.rel_cnt + 3'h1;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign ready_o = (st.press_cnt == NEEDED) && (st.rel_cnt == NEEDED);
endmodule
`default_nettype wire

// ### hw/ncrh_top.sv
// Configuration request handler behind the tag block memory
`default_nettype none
module ncrh_top #(
   parameter int STAGE_N = 16
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Tag block access
   input  wire ncrh_pkg::ncrh_tag_s tag_i,
   output logic [31:0]            rd_data_o,
   // Harvester actuation pulses
   input  wire logic              act_press_i,
   input  wire logic              act_release_i,
   // Configuration outputs
   output logic [31:0]            primary_user_pin_o,
   output logic [31:0]            secondary_user_pin_o,
   output logic [7:0]             result_o,
   output logic                   update_done_o
);
   typedef struct packed {
      ncrh_pkg::ncrh_state_e state;
      logic [31:0]           request_identifier;
      logic [31:0]           update_select_mask;
      logic [31:0]           request_pin_word;
      logic [31:0]           p_pin;
      logic [31:0]           s_pin;
      logic [31:0]           allowed;
      logic [31:0]           s_allowed;
      logic [7:0]            result;
      logic                  done;
      logic [31:0]           rd_data;
      logic [STAGE_N*32-1:0] stage;
   } ncrh_top_s;

   ncrh_top_s st;
   ncrh_top_s next_st;
   logic      energy_ok;
   logic      energy_clr;

   // Result code chooser for the requesting user
   function automatic logic [7:0] pick(input ncrh_pkg::ncrh_user_e u,
                                        input logic [7:0] p_code,
                                        input logic [7:0] s_code);
      pick = (u == ncrh_pkg::USR_SECONDARY) ? s_code : p_code;
   endfunction

   // Decode of the identifier
   function automatic ncrh_pkg::ncrh_user_e who(input logic [31:0] id);
      if (id == ncrh_pkg::REQ_PRIMARY)
         who = ncrh_pkg::USR_PRIMARY;
      else if (id == ncrh_pkg::REQ_SECONDARY)
         who = ncrh_pkg::USR_SECONDARY;
      else
         who = ncrh_pkg::USR_NONE;
   endfunction

   ncrh_energy #(
      .NEEDED    (ncrh_pkg::ACT_NEEDED)
   ) u_energy (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .clear_i   (energy_clr),
      .press_i   (act_press_i),
      .release_i (act_release_i),
      .ready_o   (energy_ok)
   );

   // Request evaluation
   always_comb
   begin
      ncrh_pkg::ncrh_user_e u;
      logic [31:0]          perm;
      logic                 pin_ok;
      logic                 bad_val;
      logic [3:0]           idx;
      u          = who(st.request_identifier);
      perm       = (u == ncrh_pkg::USR_SECONDARY) ? st.s_allowed : st.allowed;
      // An identifier overwritten by an unknown code authenticates nobody
      pin_ok     = (u == ncrh_pkg::USR_PRIMARY)   ? (st.request_pin_word == st.p_pin) :
                   (u == ncrh_pkg::USR_SECONDARY) ? (st.request_pin_word == st.s_pin) :
                   1'b0;
      bad_val    = 1'b0;
      idx        = ncrh_pkg::ADDR_P_PIN_NEW[3:0] - ncrh_pkg::STAGE_IDX_LO;
      next_st    = st;
      energy_clr = 1'b0;
      next_st.done = 1'b0;
      // Reader block writes, the order of which the reader keeps
      if (tag_i.wr)
      begin
         case (tag_i.addr)
            ncrh_pkg::ADDR_REQ_ID:
            begin
               next_st.request_identifier = tag_i.data;
               if (who(tag_i.data) != ncrh_pkg::USR_NONE)
               begin
                  next_st.state  = ncrh_pkg::ST_WAIT;
                  next_st.result = pick(who(tag_i.data), ncrh_pkg::RES_P_BUSY,
                                        ncrh_pkg::RES_S_BUSY);
                  energy_clr     = 1'b1;
               end
            end
            ncrh_pkg::ADDR_SEL_MASK: next_st.update_select_mask = tag_i.data;
            ncrh_pkg::ADDR_PIN_WORD: next_st.request_pin_word = tag_i.data;
            default:
            begin
               if (tag_i.addr >= ncrh_pkg::ADDR_STAGE_LO
                   && tag_i.addr <= ncrh_pkg::ADDR_STAGE_HI)
                  next_st.stage[tag_i.addr[3:0]*32 +: 32] = tag_i.data;
            end
         endcase
      end
      // Reader block reads, optional result check
      if (tag_i.rd)
      begin
         case (tag_i.addr)
            ncrh_pkg::ADDR_REQ_ID:   next_st.rd_data = st.request_identifier;
            ncrh_pkg::ADDR_SEL_MASK: next_st.rd_data = st.update_select_mask;
            ncrh_pkg::ADDR_PIN_WORD: next_st.rd_data = st.request_pin_word;
            ncrh_pkg::ADDR_STATUS:   next_st.rd_data = {24'h0, st.result};
            default:
            begin
               if (tag_i.addr >= ncrh_pkg::ADDR_STAGE_LO
                   && tag_i.addr <= ncrh_pkg::ADDR_STAGE_HI)
                  next_st.rd_data = st.stage[tag_i.addr[3:0]*32 +: 32];
               else
                  next_st.rd_data = 32'h0;
            end
         endcase
      end
      // Execution state machine
      case (st.state)
         ncrh_pkg::ST_IDLE: ;
         ncrh_pkg::ST_WAIT:
         begin
            if (energy_ok && !(tag_i.wr && tag_i.addr == ncrh_pkg::ADDR_REQ_ID))
               next_st.state = ncrh_pkg::ST_EXEC;
         end
         ncrh_pkg::ST_EXEC:
         begin
            next_st.state = ncrh_pkg::ST_IDLE;
            next_st.done  = 1'b1;
            // A selected primary or secondary PIN value of zero counts as invalid
            if (st.update_select_mask[ncrh_pkg::SEL_P_PIN_BIT]
                && st.stage[idx*32 +: 32] == 32'h0)
               bad_val = 1'b1;
            if (st.update_select_mask[ncrh_pkg::SEL_S_PIN_BIT]
                && st.stage[(idx + 4'h1)*32 +: 32] == 32'h0)
               bad_val = 1'b1;
            if (!pin_ok)
               next_st.result = pick(u, ncrh_pkg::RES_P_PIN, ncrh_pkg::RES_S_PIN);
            else if ((st.update_select_mask & ~perm) != 32'h0)
               next_st.result = pick(u, ncrh_pkg::RES_P_PERM, ncrh_pkg::RES_S_PERM);
            else if (bad_val)
               next_st.result = pick(u, ncrh_pkg::RES_P_PARM, ncrh_pkg::RES_S_PARM);
            else
            begin
               // Commit selected credentials only when all checks pass
               next_st.result = pick(u, ncrh_pkg::RES_P_OK, ncrh_pkg::RES_S_OK);
               if (st.update_select_mask[ncrh_pkg::SEL_P_PIN_BIT])
                  next_st.p_pin = st.stage[idx*32 +: 32];
               if (st.update_select_mask[ncrh_pkg::SEL_S_PIN_BIT])
                  next_st.s_pin = st.stage[(idx + 4'h1)*32 +: 32];
            end
            // Codes chosen per user
         end
         default: next_st.state = ncrh_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st           <= '0;
         st.p_pin     <= ncrh_pkg::P_PIN_RESET;
         st.s_pin     <= ncrh_pkg::S_PIN_RESET;
         st.allowed   <= ncrh_pkg::ALLOWED_RESET;
         st.s_allowed <= ncrh_pkg::S_ALLOWED_RESET;
         st.result    <= ncrh_pkg::RES_IDLE;
      end
      else
         st <= next_st;
   end

   // Outputs
   assign rd_data_o            = st.rd_data;
   assign primary_user_pin_o   = st.p_pin;
   assign secondary_user_pin_o = st.s_pin;
   assign result_o             = st.result;
   assign update_done_o        = st.done;
endmodule
`default_nettype wire

// ### tb/ncrh_asserts.sv
// Checker of the request handler outputs against its inputs
`default_nettype none
module ncrh_asserts #(
   parameter int STAGE_N = 16
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   // Watched ports
   input  wire ncrh_pkg::ncrh_tag_s tag_i,
   input  wire logic [31:0]         rd_data_o,
   input  wire logic                act_press_i,
   input  wire logic                act_release_i,
   input  wire logic [31:0]         primary_user_pin_o,
   input  wire logic [31:0]         secondary_user_pin_o,
   input  wire logic [7:0]          result_o,
   input  wire logic                update_done_o
);
   //===========================================================================
   // Helpers
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [2:0] since;
   // Cycles since the last actuation pulse, saturating
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         since <= 3'h7;
      else
         since <= (act_press_i || act_release_i) ? 3'h0 : since + {2'h0, since != 3'h7};
   //===========================================================================
   // Assertions
   a_busy_primary:
      assert property (tag_i.wr && tag_i.addr == ncrh_pkg::ADDR_REQ_ID &&
         tag_i.data == ncrh_pkg::REQ_PRIMARY |=> result_o == ncrh_pkg::RES_P_BUSY)
      else $error("primary request not busy");
   a_busy_secondary:
      assert property (tag_i.wr && tag_i.addr == ncrh_pkg::ADDR_REQ_ID &&
         tag_i.data == ncrh_pkg::REQ_SECONDARY |=> result_o == ncrh_pkg::RES_S_BUSY)
      else $error("secondary request not busy");
   a_done_code:
      assert property (update_done_o |-> result_o inside {8'h31, 8'h71, 8'h91, 8'hb1,
         8'h39, 8'h79, 8'h99, 8'hb9})
      else $error("bad final code");
   a_done_energy:
      assert property (update_done_o |-> since <= 3'h3)
      else $error("update without actuation");
   a_ppin_guard:
      assert property ($changed(primary_user_pin_o) |->
         update_done_o && result_o == ncrh_pkg::RES_P_OK)
      else $error("primary pin changed illegally");
   a_spin_guard:
      assert property ($changed(secondary_user_pin_o) |-> update_done_o &&
         (result_o == ncrh_pkg::RES_P_OK || result_o == ncrh_pkg::RES_S_OK))
      else $error("secondary pin changed illegally");
   a_error_hold:
      assert property (update_done_o && result_o != ncrh_pkg::RES_P_OK &&
         result_o != ncrh_pkg::RES_S_OK |-> $stable(primary_user_pin_o) &&
         $stable(secondary_user_pin_o))
      else $error("pin changed on error");
   a_status_read:
      assert property (tag_i.rd && tag_i.addr == ncrh_pkg::ADDR_STATUS |=>
         rd_data_o[7:0] == result_o)
      else $error("status read differs");
endmodule
bind ncrh_top ncrh_asserts #(.STAGE_N(STAGE_N)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .tag_i(tag_i), .rd_data_o(rd_data_o), .act_press_i(act_press_i),
   .act_release_i(act_release_i), .primary_user_pin_o(primary_user_pin_o),
   .secondary_user_pin_o(secondary_user_pin_o), .result_o(result_o),
   .update_done_o(update_done_o));
`default_nettype wire

// ### tb/ncrh_reader.sv
// Reader model that accesses tag blocks and pulses the harvester
`default_nettype none
module ncrh_reader (
   // Clock
   input  wire logic                clk_i,
   // Tag access and actuations
   output var ncrh_pkg::ncrh_tag_s  tag_o,
   output var logic                 press_o,
   output var logic                 release_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      tag_o = '0;
      press_o = 1'b0;
      release_o = 1'b0;
   end
   // One block access; data inverted once the strobe drops
   task automatic acc(input logic rd, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i) tag_o <= {~rd, rd, a, d};
      @(posedge clk_i) tag_o <= {2'b00, a, ~d};
   endtask
   // Presses then releases, one idle cycle after each pulse
   task automatic act(input int np, input int nr);
      repeat (np)
      begin
         @(posedge clk_i) press_o <= 1'b1;
         @(posedge clk_i) press_o <= 1'b0;
      end
      repeat (nr)
      begin
         @(posedge clk_i) release_o <= 1'b1;
         @(posedge clk_i) release_o <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### tb/tb_ncrh_top.sv
// Self-checking testbench of the configuration request handler
`default_nettype none
module tb_ncrh_top;
   timeunit 1ns;
   timeprecision 1ps;
   //===========================================================================
   // Signals
   logic                clk_i = 1'b0;
   logic                rst_n_i = 1'b0;
   ncrh_pkg::ncrh_tag_s tag;
   logic [31:0]         rd_data, p_pin, s_pin, pin, v;
   logic [31:0]         ep = ncrh_pkg::P_PIN_RESET;
   logic [31:0]         es = ncrh_pkg::S_PIN_RESET;
   logic [7:0]          result, id, mask, a, res;
   logic                press, rel, done, seen;
   int                  n_mismatch = 0;
   int                  n_tests = 0;
   // Identifier, pin, mask, stage block, value, final code
   logic [95:0]         rows [10] = '{
      {8'h11, 32'he535_0003, 8'h40, 8'h79, 32'h1234_5678, 8'h71},
      {8'h19, 32'he535_0002, 8'h80, 8'h7a, 32'h0000_0001, 8'h79},
      {8'h19, 32'he535_0003, 8'h40, 8'h79, 32'h1234_5678, 8'h99},
      {8'h11, 32'he535_0002, 8'h08, 8'h73, 32'h0000_0001, 8'h91},
      {8'h11, 32'he535_0002, 8'h80, 8'h7a, 32'h0000_0000, 8'hb1},
      {8'h19, 32'he535_0003, 8'h80, 8'h7a, 32'h0000_0000, 8'hb9},
      {8'h19, 32'he535_0003, 8'h80, 8'h7a, 32'h1234_5678, 8'h39},
      {8'h11, 32'he535_0002, 8'h40, 8'h79, 32'h0a0b_0c0d, 8'h31},
      {8'h11, 32'h0a0b_0c0d, 8'h80, 8'h7a, 32'he535_0003, 8'h31},
      {8'h11, 32'he535_0002, 8'h40, 8'h79, 32'h0000_0001, 8'h71}};
   always #5 clk_i = ~clk_i;
   ncrh_reader rdr (.clk_i(clk_i), .tag_o(tag), .press_o(press), .release_o(rel));
   ncrh_top #(.STAGE_N(16)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tag_i(tag),
      .rd_data_o(rd_data), .act_press_i(press), .act_release_i(rel),
      .primary_user_pin_o(p_pin), .secondary_user_pin_o(s_pin), .result_o(result),
      .update_done_o(done));
   //===========================================================================
   // Tasks
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic results();
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Identifier, pin, mask and value written in order
   task automatic req(input logic [7:0] i, input logic [31:0] p, input logic [7:0] m,
                      input logic [7:0] b, input logic [31:0] d);
      rdr.acc(1'b0, ncrh_pkg::ADDR_REQ_ID, {24'h0, i});
      #1 chk(result === (i == 8'h11 ? 8'h51 : 8'h59), "busy");
      rdr.acc(1'b0, ncrh_pkg::ADDR_PIN_WORD, p);
      rdr.acc(1'b0, ncrh_pkg::ADDR_SEL_MASK, {24'h0, m});
      rdr.acc(1'b0, b, d);
   endtask
   // Watch for completion, then compare code, pins and status block
   task automatic fin(input logic xd, input logic [7:0] r);
      seen = 1'b0;
      repeat (6)
      begin
         @(posedge clk_i);
         #1 seen = seen | (done === 1'b1);
      end
      chk(seen === xd, "done");
      chk(result === r, "result");
      chk(p_pin === ep && s_pin === es, "pins");
      rdr.acc(1'b1, ncrh_pkg::ADDR_STATUS, 32'h0);
      #1 chk(rd_data[7:0] === r, "status");
   endtask
   //===========================================================================
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1 chk(p_pin === ep && s_pin === es && result === 8'h00 && done === 1'b0, "reset");
      rdr.acc(1'b1, 8'h60, 32'h0);
      #1 chk(rd_data === 32'h0, "unmapped");
      foreach (rows[i])
      begin
         {id, pin, mask, a, v, res} = rows[i];
         req(id, pin, mask, a, v);
         rdr.act(5, 5);
         if (res == 8'h31 || res == 8'h39)
         begin
            if (mask[6])
               ep = v;
            if (mask[7])
               es = v;
         end
         fin(1'b1, res);
      end
      // Restart clears counts; one press short must not execute
      req(8'h11, ep, 8'h40, ncrh_pkg::ADDR_P_PIN_NEW, 32'h1234_5678);
      rdr.act(3, 3);
      req(8'h11, ep, 8'h40, ncrh_pkg::ADDR_P_PIN_NEW, 32'h1234_5678);
      rdr.act(4, 5);
      fin(1'b0, ncrh_pkg::RES_P_BUSY);
      rdr.act(1, 0);
      ep = 32'h1234_5678;
      fin(1'b1, ncrh_pkg::RES_P_OK);
      // Unknown identifier after a secondary request must not borrow primary rights
      req(8'h19, es, 8'h40, ncrh_pkg::ADDR_P_PIN_NEW, 32'h0bad_0001);
      rdr.acc(1'b0, ncrh_pkg::ADDR_REQ_ID, 32'h0000_0022);
      rdr.act(5, 5);
      fin(1'b1, ncrh_pkg::RES_P_PIN);
      results();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #50000;
      n_mismatch++;
      results();
   end
endmodule
`default_nettype wire
